// ---- tapd_pkg.sv ----
// Shared constants and types for the test access port and debug event link.
package tapd_pkg;

    // ====================================================================
    // Test controller states
    typedef enum logic [3:0]
    {
        TAP_RESET,
        TAP_IDLE,
        TAP_SEL_DR,
        TAP_CAP_DR,
        TAP_SHIFT_DR,
        TAP_EXIT1_DR,
        TAP_PAUSE_DR,
        TAP_EXIT2_DR,
        TAP_UPD_DR,
        TAP_SEL_IR,
        TAP_CAP_IR,
        TAP_SHIFT_IR,
        TAP_EXIT1_IR,
        TAP_PAUSE_IR,
        TAP_EXIT2_IR,
        TAP_UPD_IR
    } tapd_state_t;

    // ====================================================================
    // Widths, reset values and timing
    localparam int IR_WIDTH = 4;
    localparam int DR_WIDTH = 32;
    localparam logic [IR_WIDTH-1:0] IR_RESET_VALUE = 4'h1;
    localparam logic [IR_WIDTH-1:0] IR_CAPTURE_VALUE = 4'h1;
    localparam logic [IR_WIDTH-1:0] IR_BYPASS = 4'hf;
    localparam logic [DR_WIDTH-1:0] DR_RESET_VALUE = 32'h0000_0000;
    // Arbitrary neutral identification value.
    localparam logic [DR_WIDTH-1:0] IDCODE_VALUE = 32'h1234_5671;
    localparam logic [IR_WIDTH-1:0] IR_IDCODE = 4'h1;
    localparam int DEBUG_ACK_CLOCKS = 3;
    localparam int TCK_HALF_DIV = 2;

    function automatic tapd_state_t tapd_next_state(input tapd_state_t s, input logic tms);
        case (s)
            TAP_RESET: tapd_next_state = tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tapd_next_state = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tapd_next_state = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tapd_next_state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tapd_next_state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tapd_next_state = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tapd_next_state = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tapd_next_state = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tapd_next_state = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tapd_next_state = tms ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tapd_next_state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tapd_next_state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tapd_next_state = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tapd_next_state = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tapd_next_state = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: tapd_next_state = tms ? TAP_SEL_DR : TAP_IDLE;
            default: tapd_next_state = TAP_RESET;
        endcase
    endfunction : tapd_next_state

endpackage : tapd_pkg

// ---- tapd_if.sv ----
// Interface joining the debug controller end and the device end.
`timescale 1ns/1ns
`default_nettype none
interface tapd_if;
    logic test_clock_input;
    logic trst_n;
    logic tms;
    logic tdi;
    logic tdo_o;
    logic tdo_oe_n;
    logic system_clock_output;
    logic de_dev_o;
    logic de_dev_oe_n;
    logic de_ctl_o;
    logic de_ctl_oe_n;

    // ====================================================================
    // Wired levels: pulled high when nobody drives.
    wire tdo_wire = tdo_oe_n ? 1'b1 : tdo_o;
    wire debug_event_line_n = (de_dev_oe_n | de_dev_o) & (de_ctl_oe_n | de_ctl_o);

    modport device
    (
        input test_clock_input, trst_n, tms, tdi, debug_event_line_n,
        output tdo_o, tdo_oe_n, system_clock_output, de_dev_o, de_dev_oe_n
    );
    modport ctrl
    (
        output test_clock_input, trst_n, tms, tdi, de_ctl_o, de_ctl_oe_n,
        input tdo_wire, system_clock_output, debug_event_line_n
    );
endinterface : tapd_if
`default_nettype wire

// ---- tapd_device.sv ----
// Device end: test controller on the test clock, debug event acknowledge on core_clk.
// How it works
// - Test reset low clears test logic immediately
// - All test logic runs on test clock
// - Mode-select sampled on rising edge steers controller
// - Data input captured on rising test clock
// - Data output driven only in shift states
// - Data output changes on falling test clock
// - Debug entry drives event line low three clocks
// - Event line bidirectional active low, also input
`timescale 1ns/1ns
`default_nettype none
module tapd_device
    import tapd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    tapd_if.device link,
    input wire logic debug_entry,
    output logic debug_request_in,
    output logic [tapd_pkg::IR_WIDTH-1:0] instr_out,
    output logic [tapd_pkg::DR_WIDTH-1:0] data_out,
    output logic data_update
);
    import tapd_pkg::*;

    tapd_state_t state_reg;
    logic [IR_WIDTH-1:0] ir_shift_reg;
    logic [IR_WIDTH-1:0] ir_reg;
    logic [DR_WIDTH-1:0] dr_shift_reg;
    logic [DR_WIDTH-1:0] dr_reg;
    logic bypass_reg;
    logic tdo_reg;
    logic tdo_en_reg;
    logic upd_toggle_reg;
    logic [2:0] upd_sync_reg;
    logic [2:0] ack_cnt_reg;
    logic [2:0] de_sync_reg;
    logic [1:0] ack_hist_reg;

    // True for instructions that place the user data register in the scan path.
    function automatic logic user_data_sel(input logic [IR_WIDTH-1:0] ir);
        user_data_sel = (ir != IR_BYPASS) && (ir != IR_IDCODE);
    endfunction : user_data_sel

    // ====================================================================
    // Test controller, rising edge of test clock
    always_ff @(posedge link.test_clock_input or negedge link.trst_n)
    begin
        if (!link.trst_n)
            state_reg <= TAP_RESET;
        else
            state_reg <= tapd_next_state(state_reg, link.tms);
    end

    always_ff @(posedge link.test_clock_input or negedge link.trst_n)
    begin
        if (!link.trst_n)
        begin
            ir_shift_reg <= IR_RESET_VALUE;
            ir_reg <= IR_RESET_VALUE;
        end
        else
        begin
            case (state_reg)
                TAP_RESET: ir_reg <= IR_RESET_VALUE;
                TAP_CAP_IR: ir_shift_reg <= IR_CAPTURE_VALUE;
                TAP_SHIFT_IR: ir_shift_reg <= {link.tdi, ir_shift_reg[IR_WIDTH-1:1]};
                TAP_UPD_IR: ir_reg <= ir_shift_reg;
                default: ir_shift_reg <= ir_shift_reg;
            endcase
        end
    end

    // A test reset clears the update toggle, so the core side may see one last update.
    always_ff @(posedge link.test_clock_input or negedge link.trst_n)
    begin
        if (!link.trst_n)
        begin
            dr_shift_reg <= DR_RESET_VALUE;
            dr_reg <= DR_RESET_VALUE;
            bypass_reg <= 1'b0;
            upd_toggle_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                TAP_CAP_DR:
                begin
                    dr_shift_reg <= (ir_reg == IR_IDCODE) ? IDCODE_VALUE : dr_reg;
                    bypass_reg <= 1'b0;
                end
                TAP_SHIFT_DR:
                begin
                    dr_shift_reg <= {link.tdi, dr_shift_reg[DR_WIDTH-1:1]};
                    bypass_reg <= link.tdi;
                end
                TAP_UPD_DR:
                begin
                    if (user_data_sel(ir_reg))
                    begin
                        dr_reg <= dr_shift_reg;
                        upd_toggle_reg <= ~upd_toggle_reg;
                    end
                end
                default: bypass_reg <= bypass_reg;
            endcase
        end
    end

    // ====================================================================
    // Serial output, falling edge of test clock
    always_ff @(negedge link.test_clock_input or negedge link.trst_n)
    begin
        if (!link.trst_n)
        begin
            tdo_reg <= 1'b0;
            tdo_en_reg <= 1'b0;
        end
        else
        begin
            tdo_en_reg <= (state_reg == TAP_SHIFT_IR) || (state_reg == TAP_SHIFT_DR);
            if (state_reg == TAP_SHIFT_IR)
                tdo_reg <= ir_shift_reg[0];
            else if (state_reg == TAP_SHIFT_DR)
                tdo_reg <= (ir_reg == IR_BYPASS) ? bypass_reg : dr_shift_reg[0];
        end
    end

    assign link.tdo_o = tdo_reg;
    assign link.tdo_oe_n = ~tdo_en_reg;

    // ====================================================================
    // Core side: update event crossing, debug acknowledge
    // The toggle passes three flops; the data words have settled long before it lands.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            upd_sync_reg <= 3'h0;
        else
            upd_sync_reg <= {upd_sync_reg[1:0], upd_toggle_reg};
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            instr_out <= IR_RESET_VALUE;
            data_out <= DR_RESET_VALUE;
            data_update <= 1'b0;
        end
        else
        begin
            data_update <= upd_sync_reg[2] ^ upd_sync_reg[1];
            if (upd_sync_reg[2] ^ upd_sync_reg[1])
            begin
                data_out <= dr_reg;
                instr_out <= ir_reg;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ack_cnt_reg <= 3'h0;
        else if (debug_entry && ack_cnt_reg == 3'h0)
            ack_cnt_reg <= 3'(DEBUG_ACK_CLOCKS);
        else if (ack_cnt_reg != 3'h0)
            ack_cnt_reg <= ack_cnt_reg - 3'h1;
    end

    // The event line is driven low only while the acknowledge runs.
    assign link.de_dev_o = 1'b0;
    assign link.de_dev_oe_n = (ack_cnt_reg == 3'h0);
    assign link.system_clock_output = core_clk;

    // ====================================================================
    // Event line input
    // The own acknowledge still reads low through the synchroniser for two clocks
    // after it ends; those clocks are masked from the request input as well.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ack_hist_reg <= 2'h0;
        else
            ack_hist_reg <= {ack_hist_reg[0], ack_cnt_reg != 3'h0};
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            de_sync_reg <= 3'h7;
            debug_request_in <= 1'b0;
        end
        else
        begin
            de_sync_reg <= {de_sync_reg[1:0], link.debug_event_line_n};
            if (de_sync_reg[2] == de_sync_reg[1] && ack_cnt_reg == 3'h0
                && ack_hist_reg == 2'h0)
                debug_request_in <= ~de_sync_reg[2];
        end
    end

endmodule : tapd_device
`default_nettype wire

// ---- tapd_ctrl.sv ----
// Controller end: makes the test clock by division and runs one shift per request.
`timescale 1ns/1ns
`default_nettype none
module tapd_ctrl
    import tapd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    tapd_if.ctrl link,
    input wire logic test_reset_req,
    input wire logic start,
    input wire logic [5:0] bit_count,
    input wire logic [tapd_pkg::DR_WIDTH-1:0] tms_bits,
    input wire logic [tapd_pkg::DR_WIDTH-1:0] tdi_bits,
    input wire logic debug_request,
    output logic busy,
    output logic [tapd_pkg::DR_WIDTH-1:0] tdo_bits,
    output logic done,
    output logic debug_ack
);
    import tapd_pkg::*;

    logic [1:0] div_reg;
    logic tck_reg;
    logic [5:0] left_reg;
    logic [DR_WIDTH-1:0] tms_reg;
    logic [DR_WIDTH-1:0] tdi_reg;
    logic [2:0] de_sync_reg;
    logic [1:0] req_hist_reg;

    // ====================================================================
    // Test clock divider and shift engine
    wire rise = busy && div_reg == 2'(TCK_HALF_DIV - 1) && !tck_reg;
    wire fall = div_reg == 2'(TCK_HALF_DIV - 1) && tck_reg;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            div_reg <= 2'h0;
            tck_reg <= 1'b0;
        end
        else if (busy || tck_reg)
        begin
            div_reg <= (div_reg == 2'(TCK_HALF_DIV - 1)) ? 2'h0 : div_reg + 2'h1;
            if (div_reg == 2'(TCK_HALF_DIV - 1))
                tck_reg <= ~tck_reg;
        end
        else
            div_reg <= 2'h0;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            busy <= 1'b0;
            left_reg <= 6'h0;
            tms_reg <= DR_RESET_VALUE;
            tdi_reg <= DR_RESET_VALUE;
            tdo_bits <= DR_RESET_VALUE;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (!busy && !tck_reg && start && bit_count != 6'h0)
            begin
                busy <= 1'b1;
                left_reg <= bit_count;
                tms_reg <= tms_bits;
                tdi_reg <= tdi_bits;
            end
            else if (rise)
            begin
                tdo_bits <= {link.tdo_wire, tdo_bits[DR_WIDTH-1:1]};
                left_reg <= left_reg - 6'h1;
            end
            else if (fall && busy)
            begin
                tms_reg <= tms_reg >> 1;
                tdi_reg <= tdi_reg >> 1;
                if (left_reg == 6'h0)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

    assign link.test_clock_input = tck_reg;
    assign link.tms = tms_reg[0];
    assign link.tdi = tdi_reg[0];
    assign link.trst_n = ~test_reset_req;
    assign link.de_ctl_o = 1'b0;
    assign link.de_ctl_oe_n = ~debug_request;

    // ====================================================================
    // Debug event line sampling
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            de_sync_reg <= 3'h7;
            req_hist_reg <= 2'h0;
            debug_ack <= 1'b0;
        end
        else
        begin
            de_sync_reg <= {de_sync_reg[1:0], link.debug_event_line_n};
            // The own pull still reads low through the synchroniser after release.
            req_hist_reg <= {req_hist_reg[0], debug_request};
            if (de_sync_reg[2] == de_sync_reg[1])
                debug_ack <= ~de_sync_reg[2] & ~debug_request & (req_hist_reg == 2'h0);
        end
    end

endmodule : tapd_ctrl
`default_nettype wire

// ---- tapd_props.sv ----
// Concurrent checks on the test access port and debug event link.
`timescale 1ns/1ns
`default_nettype none
module tapd_props
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic test_clock_input,
    input wire logic trst_n,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo_o,
    input wire logic tdo_oe_n,
    input wire logic de_dev_o,
    input wire logic de_dev_oe_n,
    input wire logic de_ctl_oe_n,
    input wire logic debug_event_line_n
);
    logic tms_rise_reg;
    logic tms_seen_reg;

    // ====================================================================
    // Mode-select as applied by the last rising edge, seen from the next fall.
    always_ff @(posedge test_clock_input or negedge trst_n)
    begin
        if (!trst_n)
            tms_rise_reg <= 1'b1;
        else
            tms_rise_reg <= tms;
    end

    always_ff @(negedge test_clock_input or negedge trst_n)
    begin
        if (!trst_n)
            tms_seen_reg <= 1'b1;
        else
            tms_seen_reg <= tms_rise_reg;
    end

    // ====================================================================
    // Properties
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_tdo_fall;
        !tdo_oe_n && $changed(tdo_o) |-> $fell(test_clock_input);
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("data out moved off a falling edge");

    property p_tdo_oe_fall;
        trst_n && $past(trst_n) && $changed(tdo_oe_n) |-> $fell(test_clock_input);
    endproperty
    a_tdo_oe_fall: assert property (p_tdo_oe_fall) else $error("data out enable moved badly");

    property p_tdo_shift;
        !tdo_oe_n |-> !tms_seen_reg;
    endproperty
    a_tdo_shift: assert property (p_tdo_shift) else $error("data out driven outside shift");

    property p_trst;
        !trst_n |-> tdo_oe_n;
    endproperty
    a_trst: assert property (p_trst) else $error("data out driven in test reset");

    property p_tck;
        $rose(test_clock_input) |-> ##1 test_clock_input ##1 !test_clock_input;
    endproperty
    a_tck: assert property (p_tck) else $error("test clock high time wrong");

    property p_pins_hold;
        $rose(test_clock_input) |-> $stable(tms) && $stable(tdi) ##1 $stable(tms) && $stable(tdi);
    endproperty
    a_pins_hold: assert property (p_pins_hold) else $error("mode or data moved near rise");

    property p_ack3;
        $fell(de_dev_oe_n) |-> (!de_dev_oe_n && !de_dev_o) [*3] ##1 de_dev_oe_n;
    endproperty
    a_ack3: assert property (p_ack3) else $error("acknowledge not three clocks");

    property p_ctl_line;
        !de_ctl_oe_n |-> !debug_event_line_n;
    endproperty
    a_ctl_line: assert property (p_ctl_line) else $error("event line not low when driven");

    c_ack: cover property ($fell(de_dev_oe_n));
    c_shift: cover property ($fell(tdo_oe_n));
    c_trst: cover property ($fell(trst_n));
endmodule : tapd_props
`default_nettype wire

// ---- test_access_port_debug_pins_test.sv ----
// Testbench joining the controller end and the device end.
`timescale 1ns/1ns
`default_nettype none
module test_access_port_debug_pins_test
    import tapd_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic test_reset_req = 1'b0;
    logic start = 1'b0;
    logic debug_request = 1'b0;
    logic debug_entry = 1'b0;
    logic [5:0] bit_count = 6'h01;
    logic [DR_WIDTH-1:0] tms_bits = 32'h0;
    logic [DR_WIDTH-1:0] tdi_bits = 32'h0;
    logic busy, done, debug_ack, debug_request_in, data_update;
    logic [DR_WIDTH-1:0] tdo_bits;
    logic [DR_WIDTH-1:0] data_out;
    logic [IR_WIDTH-1:0] instr_out;
    int num_errors = 0;
    int comparisons = 0;

    tapd_if link_if();
    tapd_device u_tapd_device (.core_clk(core_clk), .rst(rst), .link(link_if),
        .debug_entry(debug_entry), .debug_request_in(debug_request_in),
        .instr_out(instr_out), .data_out(data_out), .data_update(data_update));
    tapd_ctrl u_tapd_ctrl (.core_clk(core_clk), .rst(rst), .link(link_if),
        .test_reset_req(test_reset_req), .start(start), .bit_count(bit_count),
        .tms_bits(tms_bits), .tdi_bits(tdi_bits), .debug_request(debug_request),
        .busy(busy), .tdo_bits(tdo_bits), .done(done), .debug_ack(debug_ack));
    tapd_props u_tapd_props (.core_clk(core_clk), .rst(rst),
        .test_clock_input(link_if.test_clock_input), .trst_n(link_if.trst_n),
        .tms(link_if.tms), .tdi(link_if.tdi), .tdo_o(link_if.tdo_o),
        .tdo_oe_n(link_if.tdo_oe_n), .de_dev_o(link_if.de_dev_o),
        .de_dev_oe_n(link_if.de_dev_oe_n), .de_ctl_oe_n(link_if.de_ctl_oe_n),
        .debug_event_line_n(link_if.debug_event_line_n));

    always #20 core_clk = ~core_clk;

    // ====================================================================
    // Tasks
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic final_report;
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    // Runs one transfer; the bits seen are returned right-justified.
    task automatic scan(input int n, input logic [31:0] tb, input logic [31:0] db,
        output logic [31:0] q);
        int i;
        @(negedge core_clk);
        bit_count = n[5:0];
        tms_bits = tb;
        tdi_bits = db;
        start = 1'b1;
        @(negedge core_clk);
        start = 1'b0;
        i = 0;
        while (done !== 1'b1 && i < 300)
        begin
            @(negedge core_clk);
            i++;
        end
        if (i == 300)
            check("done", 32'h1, 32'h0);
        check("busy", 32'h0, {31'h0, busy});
        q = tdo_bits >> (32 - n);
    endtask : scan

    task automatic scan_chk(input string name, input int n, input logic [31:0] tb,
        input logic [31:0] db, input logic [31:0] exp);
        logic [31:0] q;
        scan(n, tb, db, q);
        check(name, exp, q);
    endtask : scan_chk

    task automatic wait_req(input logic v);
        int i;
        i = 0;
        while (debug_request_in !== v && i < 20)
        begin
            @(negedge core_clk);
            i++;
        end
        check("debug_request_in", {31'h0, v}, {31'h0, debug_request_in});
    endtask : wait_req

    // ====================================================================
    // Tests
    initial
    begin
        logic [31:0] q;
        int acks;
        int reqs;
        @(negedge core_clk);
        test_reset_req = 1'b1;
        @(negedge core_clk);
        rst = 1'b0;
        test_reset_req = 1'b0;
        scan_chk("tdo_to_idle", 6, 32'h1f, 32'h0, 32'h3f);
        scan_chk("tdo_to_shift", 3, 32'h1, 32'h0, 32'h7);
        check("tdo_oe_n", 32'h0, {31'h0, link_if.tdo_oe_n});
        scan_chk("idcode", 32, 32'h8000_0000, 32'h0, IDCODE_VALUE);
        scan(2, 32'h1, 32'h0, q);
        scan(4, 32'h3, 32'h0, q);
        scan_chk("ir_capture", 6, 32'h18, 32'h2, {26'h0, 2'b11, IR_CAPTURE_VALUE});
        scan(3, 32'h1, 32'h0, q);
        scan(32, 32'h8000_0000, 32'h5a3c_96e1, q);
        scan(2, 32'h1, 32'h0, q);
        acks = 0;
        while (data_update !== 1'b1 && acks < 20)
        begin
            @(negedge core_clk);
            acks++;
        end
        check("data_update", 32'h1, {31'h0, data_update});
        check("data_out", 32'h5a3c_96e1, data_out);
        check("instr_out", 32'h2, {28'h0, instr_out});
        scan(3, 32'h1, 32'h0, q);
        check("tdo_oe_n_shift", 32'h0, {31'h0, link_if.tdo_oe_n});
        test_reset_req = 1'b1;
        repeat (6) @(negedge core_clk);
        check("tdo_oe_n_trst", 32'h1, {31'h0, link_if.tdo_oe_n});
        check("instr_trst", {28'h0, IR_RESET_VALUE}, {28'h0, instr_out});
        test_reset_req = 1'b0;
        repeat (2) @(negedge core_clk);
        scan(4, 32'h2, 32'h0, q);
        scan_chk("idcode_after_trst", 32, 32'h8000_0000, 32'h0, IDCODE_VALUE);
        scan(2, 32'h1, 32'h0, q);
        debug_entry = 1'b1;
        @(negedge core_clk);
        debug_entry = 1'b0;
        acks = 0;
        reqs = 0;
        repeat (12)
        begin
            @(negedge core_clk);
            acks += (debug_ack === 1'b1);
            reqs += (debug_request_in !== 1'b0);
        end
        check("ack_clocks", 32'h3, 32'(acks));
        check("req_during_ack", 32'h0, 32'(reqs));
        debug_request = 1'b1;
        wait_req(1'b1);
        check("debug_ack_self", 32'h0, {31'h0, debug_ack});
        debug_request = 1'b0;
        acks = 0;
        repeat (8)
        begin
            @(negedge core_clk);
            acks += (debug_ack === 1'b1);
        end
        check("ack_after_release", 32'h0, 32'(acks));
        wait_req(1'b0);
        final_report();
    end

    initial
    begin
        #800000;
        num_errors++;
        final_report();
    end
endmodule : test_access_port_debug_pins_test
`default_nettype wire
